// ==== design/pbd_consts.svh ====
/*
 constants of the pixel bus demultiplexer: register indices, field positions,
 reset values and control codes.
 assumes it is included by bare name wherever a constant is needed.
*/
//
// Contract
// R1: pixels per bus word follow multiplex ratio
// R2: host sets return clock separately per mode
// R3: codes 52/53/54 pick 16/32/64-bit bus
// R4: codes 45/44/43/41 pick 16-bit colour formats
// R5: nibble orders s1-s8, byte order s9-s12
// R6: legacy submode takes pixels from legacy port
// R7: direct colour supports little and big endian
// R8: packed-24 pixels span bus word boundaries
// R9: bits per pixel gives forwarded colour planes
// R10: capture whole word, shift out lowest first
// R11: host writes only listed code combinations
`ifndef PBD_CONSTS_SVH
`define PBD_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PBD_IDX_FMT 6'h18
`define PBD_IDX_MUX 6'h19
`define PBD_IDX_MODE 6'h1A
`define PBD_IDX_DIV 6'h1B
`define PBD_IDX_STAT 6'h1C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PBD_MODE_CLS_BIT 0
`define PBD_MODE_SUB_LSB 4
`define PBD_MODE_BIG_BIT 8
`define PBD_STAT_OVR_BIT 0
`define PBD_STAT_ILL_BIT 1
`define PBD_STAT_BUSY_BIT 2
`define PBD_STAT_BPP_LSB 8
`define PBD_RST_FMT 8'h00
`define PBD_RST_MUX 8'h00
`define PBD_RST_MODE 9'h090
`define PBD_RST_DIV 4'h0

// ----------------------------------------------------------------
// control codes
// ----------------------------------------------------------------
`define PBD_MUX_16 8'h52
`define PBD_MUX_32 8'h53
`define PBD_MUX_64 8'h54
`define PBD_MUX_P32 8'h5B
`define PBD_MUX_P64 8'h5C
`define PBD_FMT_565 8'h45
`define PBD_FMT_1555 8'h44
`define PBD_FMT_664 8'h43
`define PBD_FMT_4444 8'h41

`endif

// ==== design/pbd_pkg.sv ====
/*
 types shared by the pixel bus demultiplexer files.
 assumes the constants header is compiled alongside.
*/
package pbd_pkg;

   // ----------------------------------------------------------------
   // shifter state and mode class
   // ----------------------------------------------------------------
   typedef enum logic {PBD_IDLE, PBD_SHIFT} pbd_state_t;
   typedef enum logic {PBD_CLS_PSEUDO, PBD_CLS_COLOUR} pbd_class_t;

endpackage

// ==== design/pbd_sync.sv ====
/*
 three flop synchroniser for pins from outside the REF_CLK domain.
 assumes the bus data settle well before the load clock edge.
*/
`timescale 1ns/1ps
module pbd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] stage2,
   output logic [WIDTH-1:0] stage3
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;

   // ----------------------------------------------------------------
   // chain; the first flop feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end else begin
         stage1_q <= din;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   assign stage2 = stage2_q;
   assign stage3 = stage3_q;
endmodule

// ==== design/pbd_mode_decode.sv ====
/*
 decodes the mode, colour format and multiplex codes into unpack settings.
 assumes the codes come from registers in the same clock domain.
*/
`timescale 1ns/1ps
`include "pbd_consts.svh"
module pbd_mode_decode (
   input wire logic cls,
   input wire logic [3:0] sub,
   input wire logic [7:0] fmt,
   input wire logic [7:0] mux,
   output logic legal,
   output logic legacy,
   output logic packed24,
   output logic swap,
   output logic [5:0] pw,
   output logic [4:0] cnt,
   output logic [3:0] bus_bytes,
   output logic [4:0] bpp,
   output logic [3:0] coff
);
   always_comb begin
      legal = 1'b1;
      legacy = 1'b0;
      packed24 = 1'b0;
      swap = 1'b0;
      pw = 6'h10;
      cnt = 5'h01;
      bus_bytes = 4'h4;
      bpp = 5'h10;
      coff = 4'h0;
      if (cls == pbd_pkg::PBD_CLS_PSEUDO) begin
         if (sub == 4'h0) begin
            legacy = 1'b1; // [R6]
            pw = 6'h08;
            bpp = 5'h08;
         end else if (sub <= 4'h8) begin
            pw = 6'h04; // [R5]
            bpp = 5'h04;
            swap = (sub >= 4'h5);
            cnt = 5'h02 << ((sub - 4'h1) & 4'h3);
         end else if (sub <= 4'hC) begin
            pw = 6'h08; // [R5]
            bpp = 5'h08;
            cnt = 5'h01 << (sub - 4'h9);
         end else begin
            legal = 1'b0;
         end
      end else begin
         unique case (mux) // [R3]
            `PBD_MUX_16: cnt = 5'h01;
            `PBD_MUX_32: cnt = 5'h02;
            `PBD_MUX_64: cnt = 5'h04;
            `PBD_MUX_P32: bus_bytes = 4'h4;
            `PBD_MUX_P64: bus_bytes = 4'h8;
            default: legal = 1'b0; // [R11]
         endcase
         if ((mux == `PBD_MUX_P32) || (mux == `PBD_MUX_P64)) begin
            bpp = 5'h18;
            pw = 6'h20;
            cnt = (mux == `PBD_MUX_P64) ? 5'h02 : 5'h01;
            unique case (fmt)
               8'h46: coff = 4'h0;
               8'h47: coff = 4'h8;
               8'h56, 8'h57, 8'h5E, 8'h5F: begin
                  packed24 = 1'b1; // [R8]
                  pw = 6'h18;
               end
               default: legal = 1'b0; // [R11]
            endcase
         end else begin
            // direct colour codes differ from true colour only in bit 6
            unique case (fmt & 8'hBF) // [R4]
               8'h05: bpp = 5'h10;
               8'h04: bpp = 5'h0F;
               8'h03: bpp = 5'h10;
               8'h01: bpp = 5'h0C;
               default: legal = 1'b0; // [R11]
            endcase
         end
      end
   end
endmodule

// ==== design/pbd_top.sv ====
/*
 pixel bus demultiplexer: captures a bus word on each rising load clock edge while the codes are legal, splits
 it into pixels by mode and shifts them out at the pixel enable rate.
 assumes an APB master, the load clock and bus as asynchronous pins, and a
 host that keeps the pixel rate fast enough to drain a word per load.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "pbd_consts.svh"
module pbd_top (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic WORD_LOAD_CLOCK,
   input wire logic [63:0] WIDE_PIXEL_BUS,
   input wire logic [7:0] LEGACY_PIXEL_PORT,
   output logic [23:0] PIXEL_DATA,
   output logic PIXEL_VALID,
   output logic [4:0] PIXEL_BITS
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [72:0] sync2;
   logic [72:0] sync3;
   logic lvl_q, lvl_d;
   logic load;
   logic [63:0] word;
   logic [7:0] legacy_word;

   logic [7:0] fmt_q, fmt_d;
   logic [7:0] mux_q, mux_d;
   logic [8:0] mode_q, mode_d;
   logic [3:0] div_sel_q, div_sel_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic ovr_clr;

   logic dec_legal, dec_legacy, dec_packed, dec_swap;
   logic [5:0] dec_pw;
   logic [4:0] dec_cnt;
   logic [3:0] dec_bytes;
   logic [4:0] dec_bpp;
   logic [3:0] dec_coff;

   pbd_pkg::pbd_state_t state_q, state_d;
   logic [79:0] latch_q, latch_d;
   logic [4:0] idx_q, idx_d;
   logic [4:0] cnt_q, cnt_d;
   logic [5:0] pw_q, pw_d;
   logic swap_q, swap_d;
   logic big_q, big_d;
   logic [3:0] coff_q, coff_d;
   logic [4:0] bpp_q, bpp_d;
   logic [1:0] res_q, res_d;
   logic [15:0] resd_q, resd_d;
   logic [3:0] div_q, div_d;
   logic [23:0] pix_q, pix_d;
   logic valid_q, valid_d;
   logic [4:0] bits_q, bits_d;
   logic ovr_q, ovr_d;

   logic tick;
   logic last;
   logic [4:0] order;
   logic [7:0] off;
   logic [79:0] shifted;
   logic [79:0] coloured;
   logic [24:0] mask;
   logic [3:0] avail;
   logic [1:0] pk_n;
   logic [79:0] stream;

   // ----------------------------------------------------------------
   // pin synchronisers and load edge
   // ----------------------------------------------------------------
   pbd_sync #(
      .WIDTH(73)
   ) u_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .din({WORD_LOAD_CLOCK, LEGACY_PIXEL_PORT, WIDE_PIXEL_BUS}),
      .stage2(sync2),
      .stage3(sync3)
   );

   // a level change counts only once two stages agree, which rejects a one-flop glitch
   always_comb begin
      lvl_d = (sync2[72] == sync3[72]) ? sync3[72] : lvl_q;
      load = lvl_d & ~lvl_q; // [R10]
      word = sync3[63:0];
      legacy_word = sync3[71:64];
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lvl_q <= 1'b0;
      end else begin
         lvl_q <= lvl_d;
      end
   end

   // ----------------------------------------------------------------
   // mode decoder
   // ----------------------------------------------------------------
   pbd_mode_decode u_dec (
      .cls(mode_q[`PBD_MODE_CLS_BIT]),
      .sub(mode_q[`PBD_MODE_SUB_LSB +: 4]),
      .fmt(fmt_q),
      .mux(mux_q),
      .legal(dec_legal),
      .legacy(dec_legacy),
      .packed24(dec_packed),
      .swap(dec_swap),
      .pw(dec_pw),
      .cnt(dec_cnt),
      .bus_bytes(dec_bytes),
      .bpp(dec_bpp),
      .coff(dec_coff)
   );

   // ----------------------------------------------------------------
   // APB register file, zero wait states
   // ----------------------------------------------------------------
   // read data is registered in the setup cycle so it is stable for the access phase
   always_comb begin
      fmt_d = fmt_q;
      mux_d = mux_q;
      mode_d = mode_q;
      div_sel_d = div_sel_q;
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      ovr_clr = 1'b0;
      if (PSEL && !PENABLE) begin
         prdata_d = 32'h00000000;
         pslverr_d = 1'b0;
         if (PADDR[1:0] != 2'b00) begin
            pslverr_d = 1'b1;
         end else begin
            unique case (PADDR[7:2])
               `PBD_IDX_FMT: prdata_d[7:0] = fmt_q;
               `PBD_IDX_MUX: prdata_d[7:0] = mux_q;
               `PBD_IDX_MODE: prdata_d[8:0] = mode_q;
               `PBD_IDX_DIV: prdata_d[3:0] = div_sel_q;
               `PBD_IDX_STAT: begin
                  prdata_d[`PBD_STAT_OVR_BIT] = ovr_q;
                  prdata_d[`PBD_STAT_ILL_BIT] = ~dec_legal;
                  prdata_d[`PBD_STAT_BUSY_BIT] = (state_q == pbd_pkg::PBD_SHIFT);
                  prdata_d[`PBD_STAT_BPP_LSB +: 5] = dec_bpp;
               end
               default: pslverr_d = 1'b1;
            endcase
         end
         // a write returns zero so stale register contents never leak onto the bus
         if (PWRITE) begin
            prdata_d = 32'h00000000;
         end
      end
      if (PSEL && PENABLE && PWRITE && !pslverr_q) begin
         unique case (PADDR[7:2])
            `PBD_IDX_FMT: fmt_d = PWDATA[7:0];
            `PBD_IDX_MUX: mux_d = PWDATA[7:0];
            `PBD_IDX_MODE: mode_d = PWDATA[8:0];
            `PBD_IDX_DIV: div_sel_d = PWDATA[3:0];
            `PBD_IDX_STAT: ovr_clr = PWDATA[`PBD_STAT_OVR_BIT];
            default: ovr_clr = 1'b0;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fmt_q <= `PBD_RST_FMT;
         mux_q <= `PBD_RST_MUX;
         mode_q <= `PBD_RST_MODE;
         div_sel_q <= `PBD_RST_DIV;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         fmt_q <= fmt_d;
         mux_q <= mux_d;
         mode_q <= mode_d;
         div_sel_q <= div_sel_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign PREADY = 1'b1;
   assign PRDATA = prdata_q;
   assign PSLVERR = pslverr_q;

   // ----------------------------------------------------------------
   // pixel extraction from the latched word
   // ----------------------------------------------------------------
   always_comb begin
      order = big_q ? (cnt_q - 5'h01 - idx_q) : idx_q; // [R7]
      if (swap_q) begin
         order = idx_q ^ 5'h01; // [R5]
      end
      off = 8'(order * pw_q); // [R10]
      shifted = latch_q >> off;
      coloured = shifted >> coff_q;
      mask = (25'h0000001 << bpp_q) - 25'h0000001; // [R9]
      tick = (div_q == 4'h0);
      last = (idx_q + 5'h01 == cnt_q);
   end

   // ----------------------------------------------------------------
   // packed-24 stream assembly
   // ----------------------------------------------------------------
   // residue of up to two bytes carries a 24-bit pixel across word boundaries
   always_comb begin
      avail = {2'b00, res_q} + dec_bytes; // [R8]
      pk_n = (avail >= 4'h9) ? 2'h3 : ((avail >= 4'h6) ? 2'h2 : 2'h1);
      // pins above a 32-bit bus may float; keep them out of the residue
      stream = ({16'h0000, (dec_bytes == 4'h4) ? {32'h00000000, word[31:0]} : word} << {res_q, 3'b000}) | {64'h0, resd_q};
   end

   // ----------------------------------------------------------------
   // capture and shift out
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      latch_d = latch_q;
      idx_d = idx_q;
      cnt_d = cnt_q;
      pw_d = pw_q;
      swap_d = swap_q;
      big_d = big_q;
      coff_d = coff_q;
      bpp_d = bpp_q;
      res_d = res_q;
      resd_d = resd_q;
      pix_d = pix_q;
      valid_d = 1'b0;
      bits_d = bits_q;
      ovr_d = ovr_q;
      div_d = tick ? div_sel_q : (div_q - 4'h1);
      if (ovr_clr) begin
         ovr_d = 1'b0;
      end
      if ((state_q == pbd_pkg::PBD_SHIFT) && tick) begin
         pix_d = coloured[23:0] & mask[23:0]; // [R9]
         valid_d = 1'b1;
         bits_d = bpp_q; // [R9]
         idx_d = idx_q + 5'h01; // [R10]
         if (last) begin
            state_d = pbd_pkg::PBD_IDLE;
         end
      end
      // a word arriving before the last one drained replaces it; the loss is flagged
      if (load && dec_legal) begin // [R11]
         if ((state_q == pbd_pkg::PBD_SHIFT) && !(tick && last)) begin
            ovr_d = 1'b1;
         end
         state_d = pbd_pkg::PBD_SHIFT;
         idx_d = 5'h00;
         div_d = div_sel_q;
         pw_d = dec_pw;
         swap_d = dec_swap;
         big_d = mode_q[`PBD_MODE_BIG_BIT] && (mode_q[`PBD_MODE_CLS_BIT] == pbd_pkg::PBD_CLS_COLOUR); // [R7]
         coff_d = dec_coff;
         bpp_d = dec_bpp;
         res_d = 2'h0;
         resd_d = 16'h0000;
         cnt_d = dec_cnt; // [R1]
         if (dec_legacy) begin
            latch_d = {72'h0, legacy_word}; // [R6]
         end else if (dec_packed) begin
            latch_d = stream; // [R8]
            cnt_d = {3'b000, pk_n};
            res_d = 2'(avail - 4'(3 * pk_n));
            resd_d = 16'(stream >> (24 * pk_n));
         end else begin
            latch_d = {16'h0000, word}; // [R10]
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= pbd_pkg::PBD_IDLE;
         latch_q <= 80'h0;
         idx_q <= 5'h00;
         cnt_q <= 5'h01;
         pw_q <= 6'h08;
         swap_q <= 1'b0;
         big_q <= 1'b0;
         coff_q <= 4'h0;
         bpp_q <= 5'h08;
         res_q <= 2'h0;
         resd_q <= 16'h0000;
         div_q <= 4'h0;
         pix_q <= 24'h000000;
         valid_q <= 1'b0;
         bits_q <= 5'h08;
         ovr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         latch_q <= latch_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         pw_q <= pw_d;
         swap_q <= swap_d;
         big_q <= big_d;
         coff_q <= coff_d;
         bpp_q <= bpp_d;
         res_q <= res_d;
         resd_q <= resd_d;
         div_q <= div_d;
         pix_q <= pix_d;
         valid_q <= valid_d;
         bits_q <= bits_d;
         ovr_q <= ovr_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PIXEL_DATA = pix_q;
   assign PIXEL_VALID = valid_q;
   // width moves with the pixel it describes, so it stands as long as the data
   assign PIXEL_BITS = bits_q; // [R9]

endmodule

// ==== tb/pbd_monitor.sv ====
/*
 checker on the ports of the pixel bus demultiplexer.
 assumes a bind onto pbd_top and a zero wait state apb slave.
*/
`timescale 1ns/1ps
module pbd_monitor (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic WORD_LOAD_CLOCK,
   input wire logic [23:0] PIXEL_DATA,
   input wire logic PIXEL_VALID,
   input wire logic [4:0] PIXEL_BITS
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic setup;
   logic mapped;
   assign setup = PSEL && !PENABLE;
   assign mapped = (PADDR[1:0] == 2'h0) && (PADDR inside {[8'h60:8'h70]});
   // ----------------------------------------
   // register bus
   // ----------------------------------------
   property p_ready; PREADY; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_bad_addr; setup && !mapped |=> PSLVERR; endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("no error on unmapped address");
   property p_good_addr; setup && mapped |=> !PSLVERR; endproperty
   a_good_addr: assert property (p_good_addr) else $error("error on mapped address");
   property p_wr_zero; setup && PWRITE |=> PRDATA == 32'h0; endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("read data on a write");
   property p_rd_hold; PSEL && PENABLE |=> $stable(PRDATA); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved after access");
   // ----------------------------------------
   // pixel stream
   // ----------------------------------------
   // first pixel waits a full divider period, up to sixteen cycles
   property p_first_pix; $rose(WORD_LOAD_CLOCK) |-> ##[3:21] PIXEL_VALID; endproperty
   a_first_pix: assert property (p_first_pix) else $error("no pixel after load");
   property p_hold; !PIXEL_VALID |-> $stable(PIXEL_DATA) && $stable(PIXEL_BITS); endproperty
   a_hold: assert property (p_hold) else $error("pixel moved without valid");
   property p_mask; PIXEL_VALID |-> (PIXEL_DATA >> PIXEL_BITS) == 24'h0; endproperty
   a_mask: assert property (p_mask) else $error("pixel bits above width");
   property p_bits; PIXEL_VALID |-> PIXEL_BITS inside {5'h04, 5'h08, 5'h0C, 5'h0F, 5'h10, 5'h18}; endproperty
   a_bits: assert property (p_bits) else $error("pixel width not listed");
   c_pix16: cover property (PIXEL_VALID && PIXEL_BITS == 5'h10);
   c_pix4: cover property (PIXEL_VALID && PIXEL_BITS == 5'h04);
   c_err: cover property (PSEL && PENABLE && PSLVERR);
endmodule

bind pbd_top pbd_monitor i_pbd_monitor (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .WORD_LOAD_CLOCK(WORD_LOAD_CLOCK), .PIXEL_DATA(PIXEL_DATA), .PIXEL_VALID(PIXEL_VALID), .PIXEL_BITS(PIXEL_BITS));

// ==== tb/pbd_gfx_model.sv ====
/*
 graphics controller model driving the load clock and the pixel buses.
 assumes the bench calls send once per word; the link stands still between.
*/
`timescale 1ns/1ps
module pbd_gfx_model (
   output logic word_load_clock,
   output logic [63:0] wide_pixel_bus,
   output logic [7:0] legacy_pixel_port
);
   initial begin
      word_load_clock = 1'b0;
      wide_pixel_bus = 64'h0;
      legacy_pixel_port = 8'h0;
   end
   // ----------------------------------------
   // one load per word, data held 4+ cycles each side
   // ----------------------------------------
   // return clock is not modelled; the pixel rate comes from the divider
   task automatic send(input logic [63:0] w, input logic [7:0] l);
      #2;
      wide_pixel_bus = w;
      legacy_pixel_port = l;
      #40;
      word_load_clock = 1'b1; // whole word latched on the rise
      #40;
      word_load_clock = 1'b0;
      wide_pixel_bus = ~w; // released bus no longer shows the word
      legacy_pixel_port = ~l;
      // low phase completes the 120 ns load period
      #38;
   endtask
endmodule

// ==== tb/testbench.sv ====
/*
 self checking bench for the pixel bus demultiplexer.
 assumes the design files and the graphics controller model compile first.
*/
`timescale 1ns/1ps
`include "pbd_consts.svh"
module testbench;
   logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, wlc, pix_valid, er;
   logic [63:0] wbus;
   logic [7:0] lport;
   logic [23:0] pix_data;
   logic [4:0] pix_bits;
   logic [23:0] q_d[$], e_d[$];
   logic [4:0] q_b[$], e_b[$];
   int q_t[$];
   int err_count = 0, cmp_count = 0, cyc = 0, gap = 1;
   logic [63:0] w = 64'hFEDC_BA98_7654_3210;
   logic [5:0] ri[4] = '{`PBD_IDX_FMT, `PBD_IDX_MUX, `PBD_IDX_MODE, `PBD_IDX_DIV};
   logic [31:0] rv[4] = '{32'h0, 32'h0, 32'h090, 32'h0};
   logic [7:0] fm[4] = '{`PBD_FMT_565, `PBD_FMT_1555, `PBD_FMT_664, `PBD_FMT_4444};
   logic [4:0] bp[4] = '{5'h10, 5'h0F, 5'h10, 5'h0C};
   logic [95:0] pk;
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   pbd_top i_pbd_top (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WORD_LOAD_CLOCK(wlc), .WIDE_PIXEL_BUS(wbus), .LEGACY_PIXEL_PORT(lport),
      .PIXEL_DATA(pix_data), .PIXEL_VALID(pix_valid), .PIXEL_BITS(pix_bits));
   pbd_gfx_model i_pbd_gfx_model (.word_load_clock(wlc), .wide_pixel_bus(wbus), .legacy_pixel_port(lport));
   // ----------------------------------------
   // collector and timeout
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (pix_valid === 1'b1) begin
         q_d.push_back(pix_data);
         q_b.push_back(pix_bits);
         q_t.push_back(cyc);
      end
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // ----------------------------------------
   // apb master and pixel helpers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [5:0] i, input logic [31:0] d);
      apb(1'b1, {i, 2'b00}, d);
   endtask
   task automatic ex(input logic [23:0] d, input logic [4:0] b);
      e_d.push_back(d);
      e_b.push_back(b);
   endtask
   task automatic pix_chk(input string n);
      int k;
      k = 0;
      while (q_d.size() < e_d.size() && k < 400) begin
         @(posedge ref_clk);
         k++;
      end
      repeat (8) @(posedge ref_clk);
      chk({n, " count"}, e_d.size(), q_d.size());
      foreach (e_d[i]) if (i < q_d.size()) begin
         chk(n, e_d[i], q_d[i]);
         chk({n, " bits"}, e_b[i], q_b[i]);
      end
      // last two pixels share a word even when packed pixels span loads
      if (q_t.size() > 1) chk({n, " gap"}, gap, q_t[q_t.size() - 1] - q_t[q_t.size() - 2]);
      q_d.delete();
      q_b.delete();
      q_t.delete();
      e_d.delete();
      e_b.delete();
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      int n, j;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (ri[i]) begin
         apb(1'b0, {ri[i], 2'b00}, 32'h0);
         chk("reset value", rv[i], rd);
         chk("mapped err", 32'h0, er);
      end
      apb(1'b0, 8'h74, 32'h0);
      chk("unmapped err", 32'h1, er);
      apb(1'b1, 8'h61, 32'hFF);
      chk("unaligned err", 32'h1, er);
      wreg(`PBD_IDX_FMT, 32'h1AB);
      apb(1'b0, {`PBD_IDX_FMT, 2'b00}, 32'h0);
      chk("format field", 32'hAB, rd);
      for (int s = 0; s <= 12; s++) begin
         wreg(`PBD_IDX_MODE, 32'(s) << 4);
         n = (s == 0) ? 1 : (s <= 4) ? (2 << (s - 1)) : (s <= 8) ? (2 << (s - 5)) : (1 << (s - 9));
         for (int i = 0; i < n; i++) begin
            j = (s > 4) ? (i ^ 1) : i;
            if (s == 0) ex(24'h3C, 5'h08);
            else if (s <= 8) ex(24'(w[4*j+:4]), 5'h04);
            else ex(24'(w[8*i+:8]), 5'h08);
         end
         i_pbd_gfx_model.send(w, 8'h3C);
         pix_chk("pseudo");
      end
      for (int f = 0; f < 4; f++) for (int m = 0; m < 3; m++) begin
         wreg(`PBD_IDX_FMT, fm[f]);
         wreg(`PBD_IDX_MUX, `PBD_MUX_16 + m);
         wreg(`PBD_IDX_MODE, (m == 2 && f == 0) ? 32'h101 : 32'h001);
         for (int i = 0; i < (1 << m); i++) begin
            j = (m == 2 && f == 0) ? (3 - i) : i;
            ex(24'(w[16*j+:16]) & ((24'h1 << bp[f]) - 24'h1), bp[f]);
         end
         i_pbd_gfx_model.send(w, 8'h00);
         pix_chk("colour");
      end
      apb(1'b0, {`PBD_IDX_STAT, 2'b00}, 32'h0);
      chk("stat bpp", 32'h0C, (rd >> `PBD_STAT_BPP_LSB) & 32'h1F);
      chk("stat legal", 32'h0, (rd >> `PBD_STAT_ILL_BIT) & 32'h1);
      wreg(`PBD_IDX_MUX, `PBD_MUX_P32);
      apb(1'b0, {`PBD_IDX_STAT, 2'b00}, 32'h0);
      chk("stat illegal", 32'h1, (rd >> `PBD_STAT_ILL_BIT) & 32'h1);
      wreg(`PBD_IDX_FMT, 32'h56);
      pk = {~w[31:0], w};
      for (int p = 0; p < 4; p++) ex(pk[24*p+:24], 5'h18);
      for (int i = 0; i < 3; i++) i_pbd_gfx_model.send({32'h0, pk[32*i+:32]}, 8'h00);
      pix_chk("packed");
      wreg(`PBD_IDX_DIV, 32'h3);
      wreg(`PBD_IDX_MODE, 32'h0A0);
      gap = 4;
      ex(24'h10, 5'h08);
      ex(24'h32, 5'h08);
      i_pbd_gfx_model.send(w, 8'h00);
      pix_chk("divider");
      end_sim();
   end
endmodule
